// ===== verilog/cipl_pkg.sv
package cipl_pkg;

    // Processor register numbers
    localparam logic [7:0] CIPL_ADDR_PRIO      = 8'h12;
    localparam logic [7:0] CIPL_ADDR_SOFT_REQ  = 8'h14;
    localparam logic [7:0] CIPL_ADDR_SOFT_SUM  = 8'h15;
    localparam logic [7:0] CIPL_ADDR_MAP_EN    = 8'h38;

    // Priority levels
    localparam logic [4:0] CIPL_LVL_HALT       = 5'h1F;
    localparam logic [4:0] CIPL_LVL_PWR        = 5'h1E;
    localparam logic [4:0] CIPL_LVL_MEMERR     = 5'h1D;
    localparam logic [4:0] CIPL_LVL_CRD        = 5'h1A;
    localparam logic [4:0] CIPL_LVL_BR7        = 5'h17;
    localparam logic [4:0] CIPL_LVL_BR6        = 5'h16;
    localparam logic [4:0] CIPL_LVL_BR5        = 5'h15;
    localparam logic [4:0] CIPL_LVL_BR4        = 5'h14;
    localparam logic [4:0] CIPL_LVL_ZERO       = 5'h00;

    // Vector offsets
    localparam logic [15:0] CIPL_VEC_PWR       = 16'h000C;
    localparam logic [15:0] CIPL_VEC_MEMERR    = 16'h0060;
    localparam logic [15:0] CIPL_VEC_CRD       = 16'h0054;
    localparam logic [15:0] CIPL_VEC_BUS_BASE  = 16'h0200;
    localparam logic [15:0] CIPL_VEC_CON_RX    = 16'h00F8;
    localparam logic [15:0] CIPL_VEC_CON_TX    = 16'h00F6;
    localparam logic [15:0] CIPL_VEC_TMR0      = 16'h0078;
    localparam logic [15:0] CIPL_VEC_TMR1      = 16'h007C;
    localparam logic [15:0] CIPL_VEC_STOR      = 16'h0104;
    localparam logic [15:0] CIPL_VEC_NET       = 16'h010C;
    localparam logic [15:0] CIPL_VEC_DOORBELL  = 16'h0204;
    localparam logic [15:0] CIPL_VEC_SOFT_BASE = 16'h0080;
    localparam logic [15:0] CIPL_VEC_NONE      = 16'h0000;

    // Halt codes
    localparam logic [5:0] CIPL_HALT_EXT       = 6'h02;
    localparam logic [5:0] CIPL_HALT_RESET     = 6'h03;

    // Field positions
    localparam int CIPL_PSL_IPL_LO             = 16;
    localparam int CIPL_PSL_IPL_HI             = 20;
    localparam int CIPL_SCR_HALT_SEL           = 7;

    // Level-14 source index within on_module vector
    typedef struct packed {
        logic con_rx;
        logic con_tx;
        logic tmr0;
        logic tmr1;
        logic stor;
        logic net;
        logic doorbell;
    } cipl_lvl14_t;

    typedef struct packed {
        logic internal_data_address_bus_parity;
        logic bus_nxm_write;
        logic mem_uncorr;
        logic internal_data_address_bus_timeout;
        logic mem_nxm;
    } cipl_memerr_t;

    typedef struct packed {
        logic        valid;
        logic [4:0]  level;
        logic [4:0]  new_ipl;
        logic [15:0] vector;
        logic        from_bus;
    } cipl_grant_t;

    // Register access port
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } cipl_reg_req_t;

endpackage : cipl_pkg

// ===== verilog/cipl_arbiter.sv
`timescale 1ns/1ps
module cipl_arbiter (
    input  wire logic                  bus_req7,
    input  wire logic                  bus_req6,
    input  wire logic                  bus_req5,
    input  wire logic                  bus_req4,
    input  wire logic [15:0]           bus_vector,
    input  wire logic                  pwr_fail,
    input  wire cipl_pkg::cipl_memerr_t memerr,
    input  wire logic                  crd_err,
    input  wire cipl_pkg::cipl_lvl14_t  lvl14,
    input  wire logic [15:1]           soft_pend,
    input  wire logic [4:0]            cur_ipl,
    output cipl_pkg::cipl_grant_t      grant
);
    import cipl_pkg::*;

    function automatic cipl_grant_t mk(input logic [4:0] lvl, input logic [4:0] nipl,
                                       input logic [15:0] vec, input logic fb);
        cipl_grant_t g;
        g.valid    = 1'b1;
        g.level    = lvl;
        g.new_ipl  = nipl;
        g.vector   = vec;
        g.from_bus = fb;
        return g;
    endfunction : mk

    cipl_grant_t best;

    ////////////////////////////////////////////////////////////////////////
    // Highest pending source wins
    always_comb begin
        best = '0;
        if (pwr_fail) begin
            best = mk(CIPL_LVL_PWR, CIPL_LVL_PWR, CIPL_VEC_PWR, 1'b0);
        end else if (|memerr) begin
            best = mk(CIPL_LVL_MEMERR, CIPL_LVL_MEMERR, CIPL_VEC_MEMERR, 1'b0);
        end else if (crd_err) begin
            best = mk(CIPL_LVL_CRD, CIPL_LVL_CRD, CIPL_VEC_CRD, 1'b0);
        end else if (bus_req7) begin
            best = mk(CIPL_LVL_BR7, CIPL_LVL_BR7, bus_vector + CIPL_VEC_BUS_BASE, 1'b1);
        end else if (bus_req6) begin
            best = mk(CIPL_LVL_BR6, CIPL_LVL_BR7, bus_vector + CIPL_VEC_BUS_BASE, 1'b1);
        end else if (bus_req5) begin
            best = mk(CIPL_LVL_BR5, CIPL_LVL_BR7, bus_vector + CIPL_VEC_BUS_BASE, 1'b1);
        end else if (bus_req4) begin
            best = mk(CIPL_LVL_BR4, CIPL_LVL_BR7, bus_vector + CIPL_VEC_BUS_BASE, 1'b1);
        end else if (lvl14.con_rx) begin
            best = mk(CIPL_LVL_BR4, CIPL_LVL_BR4, CIPL_VEC_CON_RX, 1'b0);
        end else if (lvl14.con_tx) begin
            best = mk(CIPL_LVL_BR4, CIPL_LVL_BR4, CIPL_VEC_CON_TX, 1'b0);
        end else if (lvl14.tmr0) begin
            best = mk(CIPL_LVL_BR4, CIPL_LVL_BR4, CIPL_VEC_TMR0, 1'b0);
        end else if (lvl14.tmr1) begin
            best = mk(CIPL_LVL_BR4, CIPL_LVL_BR4, CIPL_VEC_TMR1, 1'b0);
        end else if (lvl14.stor) begin
            best = mk(CIPL_LVL_BR4, CIPL_LVL_BR7, CIPL_VEC_STOR, 1'b0);
        end else if (lvl14.net) begin
            best = mk(CIPL_LVL_BR4, CIPL_LVL_BR7, CIPL_VEC_NET, 1'b0);
        end else if (lvl14.doorbell) begin
            best = mk(CIPL_LVL_BR4, CIPL_LVL_BR4, CIPL_VEC_DOORBELL, 1'b0);
        end else begin
            for (int i = 15; i >= 1; i--) begin
                if (soft_pend[i] && !best.valid) begin
                    best = mk(5'(i), 5'(i), CIPL_VEC_SOFT_BASE + 16'(i * 4), 1'b0);
                end
            end
        end
    end

    // Only above current priority
    always_comb begin
        grant = best;
        if (best.level <= cur_ipl) begin
            grant.valid = 1'b0;
        end
    end

endmodule : cipl_arbiter

// ===== verilog/cipl_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Halt sequence saves PC, status longword, mapping enable bit 0, halt code.
// - Halt sequence sets priority level to 1F.
// - Halt then jumps to resident firmware with halt code.
// - Halts ignore priority; blocked in protected space unless halt code 3.
// - Maskable take saves PC and status, raises priority, vectors via control block.
// - Bus, storage and network interrupts set priority to 17.
// - DC-good and power-good both rising from low: halt code 3.
// - DC-good recovery with power-good high: code 3, or 2 if config bit 7 set.
// - Bus initialize as auxiliary processor: halt code 3.
// - Bus halt or console break: halt code 2.
// - Power-good loss: level 1E, offset 0C.
// - Parity, NONEXISTENT_MEMORY, uncorrectable, timeout errors: level 1D, offset 60.
// - Correctable memory errors: level 1A, offset 54.
// - Bus requests 7..4 at levels 17..14, vector bus vector plus 200.
// - Level 14 on-module sources at their fixed offsets.
// - Software requests at levels 01..0F, offsets 84 to BC.
// - Priority register write loads status longword bits 20:16.
// - Soft request write sets pending bit at written level.
// - Mapping enable written 0 disables, 1 enables; bit 0 saved on halt.
module cipl_ctrl (
    input  wire logic                    ref_clk,
    input  wire logic                    nrst,
    input  wire cipl_pkg::cipl_reg_req_t reg_req,
    output logic [31:0]                  reg_rdata,
    input  wire logic                    dc_good_line,
    input  wire logic                    power_good_line,
    input  wire logic                    bus_initialize_line,
    input  wire logic                    bus_halt_line,
    input  wire logic                    bus_request_level7_n,
    input  wire logic                    bus_request_level6_n,
    input  wire logic                    bus_request_level5_n,
    input  wire logic                    bus_request_level4_n,
    input  wire logic [15:0]             bus_vector,
    input  wire logic                    aux_mode,
    input  wire logic [31:0]             sys_config,
    input  wire logic                    console_break,
    input  wire cipl_pkg::cipl_memerr_t  memerr,
    input  wire logic                    crd_err,
    input  wire cipl_pkg::cipl_lvl14_t   lvl14,
    input  wire logic                    halt_protected,
    input  wire logic                    insn_boundary,
    input  wire logic [31:0]             cur_pc,
    input  wire logic [31:0]             cur_psl,
    output logic                         halt_take,
    output logic [5:0]                   halt_code_r,
    output logic [31:0]                  saved_pc_r,
    output logic [31:0]                  saved_psl_r,
    output logic                         saved_map_r,
    output logic                         irq_take,
    output logic [15:0]                  irq_vector_r,
    output logic [4:0]                   irq_level_r,
    output logic [31:0]                  psl_r,
    output logic                         mapping_enable_r
);
    import cipl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    localparam int NPIN = 8;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_r;
    logic [NPIN-1:0] sync2_r;

    assign pin_raw = {dc_good_line, power_good_line, bus_initialize_line, bus_halt_line,
                      ~bus_request_level7_n, ~bus_request_level6_n,
                      ~bus_request_level5_n, ~bus_request_level4_n};

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    logic dcok_s;
    logic pok_s;
    logic init_s;
    logic bus_halt_line_s;
    logic [3:0] br_s;
    assign dcok_s  = sync2_r[7];
    assign pok_s   = sync2_r[6];
    assign init_s  = sync2_r[5];
    assign bus_halt_line_s = sync2_r[4];
    assign br_s    = sync2_r[3:0];

    logic dcok_d_r;
    logic pok_d_r;
    logic init_d_r;
    logic bus_halt_line_d_r;
    logic brk_d_r;
    logic pok_lost_r;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dcok_d_r  <= 1'b0;
            pok_d_r   <= 1'b0;
            init_d_r  <= 1'b0;
            bus_halt_line_d_r <= 1'b0;
            brk_d_r   <= 1'b0;
        end else begin
            dcok_d_r  <= dcok_s;
            pok_d_r   <= pok_s;
            init_d_r  <= init_s;
            bus_halt_line_d_r <= bus_halt_line_s;
            brk_d_r   <= console_break;
        end
    end

    // Power-good was low while DC-good was low
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pok_lost_r <= 1'b1;
        end else if (!dcok_s && !pok_s) begin
            pok_lost_r <= 1'b1;
        end else if (dcok_s && !dcok_d_r) begin
            pok_lost_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Non-maskable event capture
    logic dcok_rise;
    logic ev_reset;
    logic ev_ext;
    logic halt_pend_r;
    logic [5:0] halt_pcode_r;

    assign dcok_rise = dcok_s && !dcok_d_r;

    always_comb begin
        ev_reset = 1'b0;
        ev_ext   = 1'b0;
        if (dcok_rise && (pok_lost_r || !pok_s || !sys_config[CIPL_SCR_HALT_SEL])) begin
            ev_reset = 1'b1;
        end else if (dcok_rise) begin
            ev_ext = 1'b1;
        end
        if (aux_mode && init_s && !init_d_r) begin
            ev_reset = 1'b1;
        end
        if ((bus_halt_line_s && !bus_halt_line_d_r) || (console_break && !brk_d_r)) begin
            ev_ext = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            halt_pend_r  <= 1'b0;
            halt_pcode_r <= CIPL_HALT_RESET;
        end else if (ev_reset) begin
            halt_pend_r  <= 1'b1;
            halt_pcode_r <= CIPL_HALT_RESET;
        end else if (ev_ext && !(halt_pend_r && halt_pcode_r == CIPL_HALT_RESET)) begin
            halt_pend_r  <= 1'b1;
            halt_pcode_r <= CIPL_HALT_EXT;
        end else if (halt_take) begin
            halt_pend_r  <= 1'b0;
        end
    end

    // Protected space blocks all but code 3; priority level is ignored
    assign halt_take = halt_pend_r && insn_boundary
                       && (!halt_protected || halt_pcode_r == CIPL_HALT_RESET);

    ////////////////////////////////////////////////////////////////////////
    // Software pending summary
    logic [15:1] soft_pend_r;
    cipl_grant_t grant;
    logic [3:0] wr_lvl;
    assign wr_lvl = reg_req.wdata[3:0];

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            soft_pend_r <= '0;
        end else begin
            for (int i = 1; i <= 15; i++) begin
                if (reg_req.wr && reg_req.addr == CIPL_ADDR_SOFT_REQ && wr_lvl == 4'(i)) begin
                    soft_pend_r[i] <= 1'b1;
                end else if (reg_req.wr && reg_req.addr == CIPL_ADDR_SOFT_SUM) begin
                    soft_pend_r[i] <= reg_req.wdata[i];
                end else if (irq_take && grant.level == 5'(i) && !grant.from_bus
                             && grant.level < CIPL_LVL_BR4) begin
                    soft_pend_r[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Arbitration
    cipl_arbiter u_arb (
        .bus_req7   (br_s[3]),
        .bus_req6   (br_s[2]),
        .bus_req5   (br_s[1]),
        .bus_req4   (br_s[0]),
        .bus_vector (bus_vector),
        .pwr_fail   (dcok_s && !pok_s),
        .memerr     (memerr),
        .crd_err    (crd_err),
        .lvl14      (lvl14),
        .soft_pend  (soft_pend_r),
        .cur_ipl    (psl_r[CIPL_PSL_IPL_HI:CIPL_PSL_IPL_LO]),
        .grant      (grant)
    );

    assign irq_take = grant.valid && insn_boundary && !halt_take && !halt_pend_r;

    ////////////////////////////////////////////////////////////////////////
    // Status longword, saves and vectors
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            psl_r <= {11'h000, CIPL_LVL_HALT, 16'h0000};
        end else if (halt_take) begin
            psl_r <= cur_psl;
            psl_r[CIPL_PSL_IPL_HI:CIPL_PSL_IPL_LO] <= CIPL_LVL_HALT;
        end else if (irq_take) begin
            psl_r <= cur_psl;
            psl_r[CIPL_PSL_IPL_HI:CIPL_PSL_IPL_LO] <= grant.new_ipl;
        end else if (reg_req.wr && reg_req.addr == CIPL_ADDR_PRIO) begin
            psl_r[CIPL_PSL_IPL_HI:CIPL_PSL_IPL_LO] <= reg_req.wdata[4:0];
        end else begin
            psl_r <= cur_psl;
            psl_r[CIPL_PSL_IPL_HI:CIPL_PSL_IPL_LO] <= psl_r[CIPL_PSL_IPL_HI:CIPL_PSL_IPL_LO];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            saved_pc_r   <= '0;
            saved_psl_r  <= '0;
            saved_map_r  <= 1'b0;
            halt_code_r  <= CIPL_HALT_RESET;
            irq_vector_r <= CIPL_VEC_NONE;
            irq_level_r  <= CIPL_LVL_ZERO;
        end else if (halt_take) begin
            saved_pc_r   <= cur_pc;
            saved_psl_r  <= cur_psl;
            saved_map_r  <= mapping_enable_r;
            halt_code_r  <= halt_pcode_r;
        end else if (irq_take) begin
            saved_pc_r   <= cur_pc;
            saved_psl_r  <= cur_psl;
            irq_vector_r <= grant.vector;
            irq_level_r  <= grant.level;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mapping_enable_r <= 1'b0;
        end else if (reg_req.wr && reg_req.addr == CIPL_ADDR_MAP_EN) begin
            mapping_enable_r <= reg_req.wdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (reg_req.rd) begin
            unique case (reg_req.addr)
                CIPL_ADDR_PRIO:     reg_rdata <= {27'h0, psl_r[CIPL_PSL_IPL_HI:CIPL_PSL_IPL_LO]};
                CIPL_ADDR_SOFT_SUM: reg_rdata <= {16'h0, soft_pend_r, 1'b0};
                CIPL_ADDR_MAP_EN:   reg_rdata <= {31'h0, mapping_enable_r};
                default:            reg_rdata <= '0;
            endcase
        end
    end

endmodule : cipl_ctrl

// ===== bench/cipl_bus_dev.sv
`timescale 1ns/1ps
module cipl_bus_dev #(
    parameter logic [15:0] VEC_BASE = 16'h0100
) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  raise,
    input  wire logic [3:0]  dly,
    output logic      [3:0]  breq_n,
    output logic      [15:0] bus_vector
);
    logic [3:0]  act_r;
    logic [3:0]  cnt_r;
    logic [15:0] last_r;
    logic [2:0]  lvl;
    ////////////////////////////////
    // Request lines, vector, released vector inverted
    assign lvl = act_r[3] ? 3'h7 : act_r[2] ? 3'h6 : act_r[1] ? 3'h5 : 3'h4;
    assign breq_n = ~act_r;
    assign bus_vector = (act_r != 4'h0) ? VEC_BASE + {10'h0, lvl, 3'h0} : ~last_r;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            act_r <= 4'h0;
            cnt_r <= 4'h0;
        end else if (raise == 4'h0) begin
            act_r <= 4'h0;
            cnt_r <= 4'h0;
        end else if (cnt_r >= dly) begin
            act_r <= raise;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            last_r <= 16'h0;
        end else if (act_r != 4'h0) begin
            last_r <= bus_vector;
        end
    end
endmodule : cipl_bus_dev

// ===== bench/cipl_ctrl_sva.sv
`timescale 1ns/1ps
module cipl_ctrl_sva (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        insn_boundary,
    input wire logic        halt_protected,
    input wire logic [31:0] cur_pc,
    input wire logic        halt_take,
    input wire logic [5:0]  halt_code_r,
    input wire logic [31:0] saved_pc_r,
    input wire logic        saved_map_r,
    input wire logic        mapping_enable_r,
    input wire logic        irq_take,
    input wire logic [15:0] irq_vector_r,
    input wire logic [4:0]  irq_level_r,
    input wire logic [31:0] psl_r
);
    logic [4:0] ipl_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ipl_q <= 5'h1F;
        end else begin
            ipl_q <= psl_r[20:16];
        end
    end
    ////////////////////////////////
    sequence s_halt_go;
        halt_take;
    endsequence
    sequence s_halt_saved;
        saved_pc_r == $past(cur_pc) && psl_r[20:16] == 5'h1F;
    endsequence
    a_halt_state_saved: assert property (s_halt_go |=> s_halt_saved)
        else $error("halt state not saved");
    a_halt_map_saved: assert property (halt_take |=> saved_map_r == $past(mapping_enable_r))
        else $error("mapping bit not saved");
    a_protect_code_three: assert property (halt_take && halt_protected |=> halt_code_r == 6'h03)
        else $error("halt taken in protected space");
    a_take_at_boundary: assert property ((halt_take || irq_take) |-> insn_boundary)
        else $error("take off boundary");
    a_halt_beats_irq: assert property (halt_take |-> !irq_take)
        else $error("irq with halt");
    a_irq_above_ipl: assert property (irq_take |=> irq_level_r > ipl_q)
        else $error("irq not above priority");
    a_irq_new_ipl: assert property (irq_take |=> psl_r[20:16] == ((irq_level_r inside {[5'h14:5'h17]}
        && !(irq_vector_r inside {16'h00F8, 16'h00F6, 16'h0078, 16'h007C, 16'h0204})) ? 5'h17 : irq_level_r))
        else $error("wrong new priority");
    a_soft_vector: assert property (irq_take ##1 irq_level_r < 5'h10 |->
        irq_vector_r == 16'h0080 + {9'h0, irq_level_r, 2'h0})
        else $error("wrong soft vector");
endmodule : cipl_ctrl_sva

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import cipl_pkg::*;
    typedef struct packed {logic [4:0] lvl; logic [4:0] interrupt_priority_level; logic [15:0] vec;} cipl_exp_t;
    logic          ref_clk;
    logic          nrst;
    cipl_reg_req_t reg_req;
    logic [31:0]   reg_rdata;
    logic          dc_good_line;
    logic          power_good_line;
    logic          bus_initialize_line;
    logic          bus_halt_line;
    logic [3:0]    breq_n;
    logic [15:0]   bus_vector;
    logic          aux_mode;
    logic [31:0]   sys_config;
    logic          console_break;
    cipl_memerr_t  memerr;
    logic          crd_err;
    cipl_lvl14_t   lvl14;
    logic          halt_protected;
    logic          insn_boundary;
    logic [31:0]   cur_pc;
    logic [31:0]   cur_psl;
    logic          halt_take;
    logic [5:0]    halt_code_r;
    logic [31:0]   saved_pc_r;
    logic [31:0]   saved_psl_r;
    logic          saved_map_r;
    logic          irq_take;
    logic [15:0]   irq_vector_r;
    logic [4:0]    irq_level_r;
    logic [31:0]   psl_r;
    logic          mapping_enable_r;
    logic [3:0]    raise;
    logic [3:0]    dly;
    logic [31:0]   rng;
    logic [31:0]   pc_s;
    logic [31:0]   rd_v;
    logic [31:0]   v;
    logic          map_e;
    int            err_count;
    int            compares;
    cipl_ctrl cipl_ctrl_inst (.ref_clk, .nrst, .reg_req, .reg_rdata, .dc_good_line, .power_good_line,
        .bus_initialize_line, .bus_halt_line, .bus_request_level7_n(breq_n[3]), .bus_request_level6_n(breq_n[2]),
        .bus_request_level5_n(breq_n[1]), .bus_request_level4_n(breq_n[0]), .bus_vector, .aux_mode, .sys_config,
        .console_break, .memerr, .crd_err, .lvl14, .halt_protected, .insn_boundary, .cur_pc, .cur_psl, .halt_take,
        .halt_code_r, .saved_pc_r, .saved_psl_r, .saved_map_r, .irq_take, .irq_vector_r, .irq_level_r, .psl_r,
        .mapping_enable_r);
    cipl_bus_dev cipl_bus_dev_inst (.ref_clk, .nrst, .raise, .dly, .breq_n, .bus_vector);
    ////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    always @(negedge ref_clk) begin
        rng = xs(rng);
        cur_pc <= rng;
        cur_psl <= ~rng;
    end
    function automatic cipl_exp_t model(input int i);
        logic [15:0] v14 [7] = '{16'h00F8, 16'h00F6, 16'h0078, 16'h007C, 16'h0104, 16'h010C, 16'h0204};
        cipl_exp_t e;
        if (i == 0) e = '{5'h1E, 5'h1E, 16'h000C};
        else if (i < 6) e = '{5'h1D, 5'h1D, 16'h0060};
        else if (i == 6) e = '{5'h1A, 5'h1A, 16'h0054};
        else if (i < 14) e = '{5'h14, (i == 11 || i == 12) ? 5'h17 : 5'h14, v14[i - 7]};
        else if (i < 18) e = '{5'h17 - 5'(i - 14), 5'h17, 16'h0300 + 16'(8 * (21 - i))};
        else e = '{5'(i - 17), 5'(i - 17), 16'h0080 + 16'(4 * (i - 17))};
        return e;
    endfunction : model
    ////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge ref_clk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge ref_clk);
        reg_req = '0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge ref_clk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(negedge ref_clk);
        reg_req = '0;
        rd_v = reg_rdata;
    endtask : rd
    task automatic wait_take(input logic hlt);
        int n;
        n = 0;
        insn_boundary = 1'b1;
        #1;
        while ((hlt ? halt_take : irq_take) !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            #1;
            n++;
        end
        pc_s = cur_pc;
        chk("take", 32'h1, n < 40);
        @(negedge ref_clk);
        insn_boundary = 1'b0;
    endtask : wait_take
    task automatic quiet(input logic hlt);
        insn_boundary = 1'b1;
        repeat (8) begin
            @(negedge ref_clk);
            #1;
            chk("no_take", 32'h0, hlt ? halt_take : irq_take);
        end
        insn_boundary = 1'b0;
    endtask : quiet
    task automatic halt_chk(input logic [5:0] code);
        wait_take(1'b1);
        chk("halt_code", code, halt_code_r);
        chk("saved_pc", pc_s, saved_pc_r);
        chk("saved_psl", ~pc_s, saved_psl_r);
        chk("saved_map", map_e, saved_map_r);
        chk("halt_ipl", 32'h1F, psl_r[20:16]);
    endtask : halt_chk
    task automatic hit(input int k);
        for (int p = 1; p >= 0; p--) begin
            if (k == 0) bus_halt_line = p[0];
            if (k == 1) console_break = p[0];
            if (k == 2 || k == 4) dc_good_line = !p[0];
            if (k == 3) bus_initialize_line = p[0];
            if (k == 4) power_good_line = !p[0];
            repeat (4) @(negedge ref_clk);
        end
    endtask : hit
    task automatic src(input int i, input logic s);
        if (i == 0) power_good_line = !s;
        else if (i < 6) memerr = s ? cipl_memerr_t'(5'h10 >> (i - 1)) : '0;
        else if (i == 6) crd_err = s;
        else if (i < 14) lvl14 = s ? cipl_lvl14_t'(7'h40 >> (i - 7)) : '0;
        else if (i < 18) raise = s ? 4'h8 >> (i - 14) : 4'h0;
    endtask : src
    task automatic irq_chk(input int i);
        cipl_exp_t e;
        e = model(i);
        wait_take(1'b0);
        chk("level", e.lvl, irq_level_r);
        chk("vector", e.vec, irq_vector_r);
        chk("irq_pc", pc_s, saved_pc_r);
        chk("irq_psl", ~pc_s, saved_psl_r);
        chk("new_ipl", e.interrupt_priority_level, psl_r[20:16]);
    endtask : irq_chk
    task automatic stop_test();
        if (err_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test
    ////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        stop_test();
    end
    initial begin
        {nrst, bus_initialize_line, bus_halt_line, aux_mode, console_break, crd_err, insn_boundary} = '0;
        {reg_req, memerr, lvl14, raise, dly, sys_config, map_e, err_count, compares} = '0;
        {dc_good_line, power_good_line, halt_protected} = 3'h7;
        rng = 32'h7B90;
        repeat (2) @(negedge ref_clk);
        nrst = 1'b1;
        rd(8'h12);
        chk("ipl_reset", 32'h1F, rd_v);
        rd(8'h40);
        chk("unmapped", 32'h0, rd_v);
        halt_chk(6'h03);
        hit(0);
        quiet(1'b1);
        halt_protected = 1'b0;
        halt_chk(6'h02);
        wr(8'h38, 32'h1);
        map_e = 1'b1;
        rd(8'h38);
        chk("map_en", 32'h1, rd_v);
        hit(1);
        halt_chk(6'h02);
        wr(8'h38, 32'h0);
        map_e = 1'b0;
        sys_config = 32'h80;
        hit(2);
        halt_chk(6'h02);
        sys_config = 32'h7F;
        hit(2);
        halt_chk(6'h03);
        aux_mode = 1'b1;
        hit(3);
        halt_chk(6'h03);
        hit(4);
        halt_chk(6'h03);
        v = rng;
        wr(8'h12, v);
        rd(8'h12);
        chk("ipl_reg", {27'h0, v[4:0]}, rd_v);
        chk("psl_ipl", v[4:0], psl_r[20:16]);
        for (int i = 0; i < 33; i++) begin
            wr(8'h12, 32'h0);
            dly = rng[0] ? 4'h5 : 4'h0;
            src(i, 1'b1);
            if (i >= 18) wr(8'h14, 32'(i - 17));
            rd(8'h15);
            chk("pending", (i >= 18) ? 32'h1 << (i - 17) : 32'h0, rd_v);
            irq_chk(i);
            src(i, 1'b0);
            rd(8'h15);
            chk("cleared", 32'h0, rd_v);
            repeat (4) @(negedge ref_clk);
        end
        wr(8'h12, 32'h0);
        src(13, 1'b1);
        src(6, 1'b1);
        irq_chk(6);
        quiet(1'b0);
        src(6, 1'b0);
        wr(8'h12, 32'h0);
        irq_chk(13);
        src(13, 1'b0);
        stop_test();
    end
endmodule : tb_top
bind cipl_ctrl cipl_ctrl_sva cipl_ctrl_sva_inst (.ref_clk, .nrst, .insn_boundary, .halt_protected, .cur_pc,
    .halt_take, .halt_code_r, .saved_pc_r, .saved_map_r, .mapping_enable_r, .irq_take, .irq_vector_r,
    .irq_level_r, .psl_r);
